/* File: secondary_serial_port.sv */
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_two_defines.svh"

module secondary_serial_port #(
  parameter logic [15:0] BAUD_DIV_RESET = `SP2_BAUD_RESET
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic irq
);
  import serial_port_two_pkg::*;

  generate
    if (BAUD_DIV_RESET < `SP2_BAUD_MIN) begin : g_bad_baud
      $error("baud divisor reset value below two cycles");
    end
  endgenerate

  // registers
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] rxbuf_reg;
  logic [15:0] baud_reg;
  logic [1:0] istat_reg, istat_next;
  logic [1:0] imask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg, pslverr_reg, irq_reg, txd_reg;

  // apb decode
  wire logic [9:0] word_idx = paddr[11:2];
  wire logic setup = psel & ~penable;
  wire logic done = psel & penable & pready_reg;
  wire logic hit_ctrl = word_idx == `SP2_CTRL_IDX;
  wire logic hit_buf = word_idx == `SP2_BUF_IDX;
  wire logic hit_baud = word_idx == `SP2_BAUD_IDX;
  wire logic hit_istat = word_idx == `SP2_ISTAT_IDX;
  wire logic hit_imask = word_idx == `SP2_IMASK_IDX;
  wire logic hit_any = hit_ctrl | hit_buf | hit_baud | hit_istat | hit_imask;
  wire logic wr_ctrl = done & pwrite & hit_ctrl;
  wire logic wr_buf = done & pwrite & hit_buf;
  wire logic wr_baud = done & pwrite & hit_baud & (pwdata[15:0] >= `SP2_BAUD_MIN);
  wire logic wr_imask = done & pwrite & hit_imask;
  wire logic rd_istat = done & ~pwrite & hit_istat;

  wire logic [31:0] rd_mux =
    hit_ctrl ? {24'h000000, ctrl_reg} :
    hit_buf ? {24'h000000, rxbuf_reg} :
    hit_baud ? {16'h0000, baud_reg} :
    hit_istat ? {30'h00000000, istat_reg} :
    hit_imask ? {30'h00000000, imask_reg} : 32'h00000000;

  // control fields
  wire logic fmt8 = ctrl_reg[`SP2_FMT_BIT];
  wire logic mpf = ctrl_reg[`SP2_MPF_BIT];
  wire logic ren = ctrl_reg[`SP2_REN_BIT];
  wire logic tb8 = ctrl_reg[`SP2_TB8_BIT];
  wire logic [15:0] baud_load = baud_reg - 16'h0001;

  // transmitter
  tx_state_t tx_st;
  logic [9:0] tx_shift;
  logic [3:0] tx_left;
  logic [15:0] tx_cnt;
  wire logic tx_load = wr_buf & (tx_st == TX_IDLE);
  wire logic tx_tick = (tx_st == TX_SEND) & (tx_cnt == 16'h0000);
  wire logic tx_done_evt = tx_tick & (tx_left == 4'h0);
  // ninth slot carries tb8, or the stop level in eight-bit frames
  wire logic tx_slot9 = fmt8 ? 1'b1 : tb8;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      tx_st <= TX_IDLE;
      tx_shift <= 10'h3FF;
      tx_left <= 4'h0;
      tx_cnt <= 16'h0000;
      txd_reg <= 1'b1;
    end else if (clk_en) begin
      case (tx_st)
        TX_IDLE: begin
          if (tx_load) begin
            tx_st <= TX_SEND;
            txd_reg <= 1'b0;
            tx_shift <= {1'b1, tx_slot9, pwdata[7:0]};
            tx_left <= fmt8 ? `SP2_TX_BITS8 : `SP2_TX_BITS9;
            tx_cnt <= baud_load;
          end
        end
        TX_SEND: begin
          if (tx_tick) begin
            if (tx_left == 4'h0) begin
              tx_st <= TX_IDLE;
              txd_reg <= 1'b1;
            end else begin
              txd_reg <= tx_shift[0];
              tx_shift <= {1'b1, tx_shift[9:1]};
              tx_left <= tx_left - 4'h1;
              tx_cnt <= baud_load;
            end
          end else begin
            tx_cnt <= tx_cnt - 16'h0001;
          end
        end
        default: begin
          tx_st <= TX_IDLE;
          txd_reg <= 1'b1;
        end
      endcase
    end
  end

  // receiver, pin synchronised by two flops
  logic rxd_s1, rxd_s2, rxd_prev;
  rx_state_t rx_st;
  logic [9:0] rx_shift;
  logic [3:0] rx_left;
  logic [15:0] rx_cnt;
  wire logic rx_fall = rxd_prev & ~rxd_s2;
  wire logic rx_tick = rx_cnt == 16'h0000;
  wire logic rx_last = (rx_st == RX_BITS) & rx_tick & (rx_left == 4'h1);
  wire logic [9:0] rx_frame = {rxd_s2, rx_shift[9:1]};
  wire logic [7:0] rx_data = fmt8 ? rx_frame[8:1] : rx_frame[7:0];
  // ninth bit in nine-bit frames, stop bit in eight-bit frames
  wire logic rx_ninth_val = fmt8 ? rx_frame[9] : rx_frame[8];
  wire logic rx_accept = rx_last & (~mpf | rx_ninth_val);

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rxd_s1 <= 1'b1;
      rxd_s2 <= 1'b1;
      rxd_prev <= 1'b1;
    end else if (clk_en) begin
      rxd_s1 <= rxd_pin;
      rxd_s2 <= rxd_s1;
      rxd_prev <= rxd_s2;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rx_st <= RX_IDLE;
      rx_shift <= 10'h000;
      rx_left <= 4'h0;
      rx_cnt <= 16'h0000;
    end else if (clk_en) begin
      case (rx_st)
        RX_IDLE: begin
          if (ren && rx_fall) begin
            rx_st <= RX_START;
            rx_cnt <= {1'b0, baud_reg[15:1]};
          end
        end
        RX_START: begin
          if (rx_tick) begin
            // a start shorter than half a bit is a glitch
            rx_st <= rxd_s2 ? RX_IDLE : RX_BITS;
            rx_cnt <= baud_load;
            rx_left <= fmt8 ? `SP2_RX_SAMPLES8 : `SP2_RX_SAMPLES9;
          end else begin
            rx_cnt <= rx_cnt - 16'h0001;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_shift <= rx_frame;
            rx_left <= rx_left - 4'h1;
            rx_cnt <= baud_load;
            if (rx_left == 4'h1) begin
              rx_st <= RX_IDLE;
            end
          end else begin
            rx_cnt <= rx_cnt - 16'h0001;
          end
        end
        default: begin
          rx_st <= RX_IDLE;
        end
      endcase
    end
  end

  // control register: software write first, hardware set wins
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = pwdata[7:0] & `SP2_CTRL_WMASK;
    end
    if (tx_done_evt) begin
      ctrl_next[`SP2_TI_BIT] = 1'b1;
    end
    if (rx_accept) begin
      ctrl_next[`SP2_RI_BIT] = 1'b1;
      ctrl_next[`SP2_RB8_BIT] = rx_ninth_val;
    end
  end

  // interrupt status, cleared by reading only the bits that were returned
  always_comb begin
    istat_next = istat_reg;
    if (rd_istat) begin
      istat_next = istat_reg & ~prdata_reg[1:0];
    end
    if (tx_done_evt) begin
      istat_next[`SP2_IRQ_TX_BIT] = 1'b1;
    end
    if (rx_accept) begin
      istat_next[`SP2_IRQ_RX_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_reg <= `SP2_CTRL_RESET;
      rxbuf_reg <= 8'h00;
      baud_reg <= BAUD_DIV_RESET;
      istat_reg <= `SP2_IRQ_RESET;
      imask_reg <= `SP2_IRQ_RESET;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      ctrl_reg <= ctrl_next;
      istat_reg <= istat_next;
      irq_reg <= |(istat_next & imask_reg);
      if (rx_accept) begin
        rxbuf_reg <= rx_data;
      end
      if (wr_baud) begin
        baud_reg <= pwdata[15:0];
      end
      if (wr_imask) begin
        imask_reg <= pwdata[1:0];
      end
    end
  end

  // apb answer: ready in the first access cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      prdata_reg <= 32'h00000000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else if (clk_en) begin
      pready_reg <= setup;
      pslverr_reg <= setup & ~hit_any;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign txd_pin = txd_reg;

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  sequence rx_start_seen;
    clk_en && rx_st == RX_IDLE && ren && rx_fall;
  endsequence

  sequence rx_start_real;
    clk_en && rx_st == RX_START && rx_tick && !rxd_s2;
  endsequence

  a_tx_start_low: assert property (clk_en && tx_load |=> !txd_pin)
    else $error("start bit not driven low");

  a_tx_ninth_bit: assert property (clk_en && tx_load && !fmt8 |=> tx_shift[8] == $past(tb8))
    else $error("ninth bit not taken from tx_ninth_bit");

  a_tx_stop_eight: assert property (clk_en && tx_load && fmt8 |=> tx_shift[9:8] == 2'b11)
    else $error("eight-bit frame lacks stop level");

  a_rx_ninth_store: assert property (clk_en && rx_accept && !fmt8
    |=> ctrl_reg[`SP2_RB8_BIT] == $past(rx_frame[8]))
    else $error("received ninth bit not stored");

  a_rx_stop_store: assert property (clk_en && rx_accept && fmt8 && !mpf
    |=> ctrl_reg[`SP2_RB8_BIT] == $past(rx_frame[9]))
    else $error("stop bit not recorded");

  a_rx_buf_load: assert property (clk_en && rx_accept |=> rxbuf_reg == $past(rx_data))
    else $error("buffer does not hold the last byte");

  a_baud_reload: assert property (clk_en && tx_load |=> tx_cnt == baud_reg - 16'h0001)
    else $error("bit timing not from baud divisor");

  a_ctrl_unused_zero: assert property (ctrl_reg[`SP2_UNUSED_BIT] == 1'b0)
    else $error("unused control bit set");

  a_tx_done_sticky: assert property (ctrl_reg[`SP2_TI_BIT] && !wr_ctrl
    |=> ctrl_reg[`SP2_TI_BIT])
    else $error("tx_done_flag cleared by hardware");

  a_tx_done_set: assert property (clk_en && tx_done_evt |=> ctrl_reg[`SP2_TI_BIT] && tx_st == TX_IDLE)
    else $error("tx_done_flag not set after frame");

  a_mp_addr_take: assert property (clk_en && rx_last && !fmt8 && mpf && rx_frame[8]
    |=> ctrl_reg[`SP2_RI_BIT] && istat_reg[`SP2_IRQ_RX_BIT])
    else $error("address frame not flagged");

  a_mp_data_drop: assert property (clk_en && rx_last && mpf && !rx_ninth_val && !wr_ctrl
    && !ctrl_reg[`SP2_RI_BIT] |=> !ctrl_reg[`SP2_RI_BIT])
    else $error("filtered frame set rx_done_flag");

  a_rx_needs_enable: assert property (clk_en && rx_st == RX_IDLE && !ren |=> rx_st == RX_IDLE)
    else $error("reception started while disabled");

  a_rx_half_bit: assert property (rx_start_seen |=> rx_st == RX_START && rx_cnt == {1'b0, baud_reg[15:1]})
    else $error("start not timed to bit centre");

  a_rx_center_step: assert property (rx_start_real |=> rx_st == RX_BITS && rx_cnt == baud_reg - 16'h0001)
    else $error("sampling not spaced by bit period");

endmodule
`default_nettype wire

/* File: serial_port_two_defines.svh */
`ifndef SERIAL_PORT_TWO_DEFINES_SVH
`define SERIAL_PORT_TWO_DEFINES_SVH

// register indices; byte address is four times the index
`define SP2_CTRL_IDX 10'h09B
`define SP2_BUF_IDX 10'h09C
`define SP2_BAUD_IDX 10'h09D
`define SP2_ISTAT_IDX 10'h09E
`define SP2_IMASK_IDX 10'h09F

`define SP2_CTRL_RESET 8'h00
`define SP2_CTRL_WMASK 8'hBF
`define SP2_BAUD_RESET 16'h00D9
`define SP2_BAUD_MIN 16'h0002
`define SP2_IRQ_RESET 2'h0

// control register fields
`define SP2_FMT_BIT 7
`define SP2_UNUSED_BIT 6
`define SP2_MPF_BIT 5
`define SP2_REN_BIT 4
`define SP2_TB8_BIT 3
`define SP2_RB8_BIT 2
`define SP2_TI_BIT 1
`define SP2_RI_BIT 0

// interrupt status / mask fields
`define SP2_IRQ_RX_BIT 0
`define SP2_IRQ_TX_BIT 1

// bit counts after the start bit
`define SP2_TX_BITS9 4'hA
`define SP2_TX_BITS8 4'h9
`define SP2_RX_SAMPLES9 4'hA
`define SP2_RX_SAMPLES8 4'h9

`endif

/* File: serial_port_two_pkg.sv */
package serial_port_two_pkg;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_BITS = 3'b100
  } rx_state_t;

endpackage

/* File: serial_node_model.sv */
`timescale 1ns/1ps
`default_nettype none

module serial_node_model (
  input wire logic core_clk,
  input wire logic txd_pin,
  output logic rxd_pin
);
  initial rxd_pin = 1'b1;

  // frame bit 0 is the start bit and goes out first
  task automatic send(input logic [10:0] f, input int nb, input int baud);
    for (int i = 0; i < nb; i++) begin
      rxd_pin <= f[i];
      repeat (baud) @(posedge core_clk);
    end
    rxd_pin <= 1'b1;
  endtask

  // samples each bit at its centre after the falling start edge
  task automatic capture(input int nb, input int baud, output logic [10:0] f, output logic ok);
    int n;
    n = 0;
    f = '1;
    while (txd_pin !== 1'b0 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    ok = (n < 500);
    repeat (baud / 2) @(negedge core_clk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd_pin;
      repeat (baud) @(negedge core_clk);
    end
  endtask
endmodule

`default_nettype wire

/* File: tb_secondary_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_two_defines.svh"

module tb_secondary_serial_port;
  localparam int B = 8;
  localparam logic [11:0] A_CTRL = {`SP2_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_BUF = {`SP2_BUF_IDX, 2'b00};
  localparam logic [11:0] A_BAUD = {`SP2_BAUD_IDX, 2'b00};
  localparam logic [11:0] A_IST = {`SP2_ISTAT_IDX, 2'b00};
  localparam logic [11:0] A_IMSK = {`SP2_IMASK_IDX, 2'b00};
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, rxd_pin, txd_pin, irq, ok;
  logic [10:0] fr;
  int miscompares = 0;
  int tests_run = 0;

  initial forever #2.5 core_clk = ~core_clk;

  secondary_serial_port dut (.core_clk(core_clk), .rstn(rstn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .irq(irq));
  serial_node_model node (.core_clk(core_clk), .txd_pin(txd_pin), .rxd_pin(rxd_pin));

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    n = 0;
    // start right after a rising edge, one idle edge after any previous transfer
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        miscompares++;
        give_verdict();
      end
      @(posedge core_clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    xfer(1'b1, a, d, r, e);
    chk({31'b0, e}, 32'h0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] r;
    logic e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'b0, e}, {31'b0, experr});
  endtask

  // receive one frame from the node and check control and buffer
  task automatic rx_case(input logic [7:0] c, input logic [10:0] f, input int nb, input logic [7:0] ec,
                         input logic [7:0] eb);
    wr(A_CTRL, {24'h0, c});
    node.send(f, nb, B);
    repeat (4) @(posedge core_clk);
    rd(A_CTRL, {24'h0, ec}, 1'b0);
    rd(A_BUF, {24'h0, eb}, 1'b0);
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(A_CTRL, 32'h0, 1'b0);
    rd(A_BAUD, 32'h0000_00D9, 1'b0);
    rd(12'h000, 32'h0, 1'b1);
    wr(A_CTRL, 32'h40);
    rd(A_CTRL, 32'h0, 1'b0);
    wr(A_BAUD, B);
    wr(A_BAUD, 32'h1);
    rd(A_BAUD, B, 1'b0);
    wr(A_IMSK, 32'h3);
    wr(A_CTRL, 32'h08);
    fork
      node.capture(11, B, fr, ok);
      wr(A_BUF, 32'hA5);
    join
    chk({21'b0, fr}, {21'b0, 1'b1, 1'b1, 8'hA5, 1'b0});
    chk({31'b0, ok}, 32'h1);
    rd(A_CTRL, 32'h0A, 1'b0);
    chk({31'b0, irq}, 32'h1);
    rd(A_IST, 32'h2, 1'b0);
    repeat (2) @(posedge core_clk);
    chk({31'b0, irq}, 32'h0);
    wr(A_CTRL, 32'h80);
    fork
      node.capture(10, B, fr, ok);
      wr(A_BUF, 32'h3C);
    join
    chk({21'b0, fr}, {21'b0, 1'b1, 1'b1, 8'h3C, 1'b0});
    rd(A_CTRL, 32'h82, 1'b0);
    rx_case(8'h10, {2'b10, 8'h5A, 1'b0}, 11, 8'h11, 8'h5A);
    rx_case(8'h30, {2'b10, 8'h77, 1'b0}, 11, 8'h30, 8'h5A);
    rx_case(8'h30, {2'b11, 8'h66, 1'b0}, 11, 8'h35, 8'h66);
    rx_case(8'h90, {2'b11, 8'hC3, 1'b0}, 10, 8'h95, 8'hC3);
    rx_case(8'h80, {2'b11, 8'h11, 1'b0}, 10, 8'h80, 8'hC3);
    rd(A_IST, 32'h3, 1'b0);
    give_verdict();
  end
endmodule

`default_nettype wire
